// ===== osc_source_select.sv
// oscillator source selection, low-power control and system clock gating
`timescale 1ns/1ps
module osc_source_select (
    input wire logic CLK,
    input wire logic RST_B,
    // configuration options
    input wire logic [1:0] CFG_FAST_SRC,
    input wire logic [1:0] CFG_RC_FREQ,
    input wire logic CFG_WATCH_EN,
    input wire logic CFG_DEDICATED_PINS,
    input wire logic CFG_WATCH_PINS_OSC,
    input wire logic CFG_SLOW_RC_EN,
    input wire logic CFG_WDT_SRC_SYS,
    // power-down request from the core
    input wire logic HALT,
    input wire logic WAKE,
    input wire logic WATCH_KEEP_IN_HALT,
    // register port
    input wire logic [7:0] ADDR,
    input wire logic [7:0] WDATA,
    input wire logic WR,
    input wire logic RD,
    output logic [7:0] RDATA,
    // oscillator controls
    output logic FAST_OSC_EN,
    output logic [1:0] FAST_OSC_SRC,
    output logic [1:0] RC_FREQ_SEL,
    output logic WATCH_OSC_EN,
    output logic WATCH_LOW_POWER,
    output logic SLOW_RC_EN,
    output logic SYS_CLK_EN,
    output logic SYS_CLK_SLOW,
    output logic [1:0] WDT_CLK_SRC,
    output logic [1:0] TB_CLK_SRC,
    // pin functions
    output logic PA5_IS_IO,
    output logic PA6_IS_IO,
    output logic WATCH_PINS_IS_IO
);
    logic [7:0] system_control_reg_0_ff;
    logic [7:0] rdata_ff;
    logic [7:0] nxt_rdata;
    osc_sel_pkg::mode_t mode_ff;
    osc_sel_pkg::mode_t nxt_mode;
    logic watch_allowed;
    logic speed_sel;
    logic low_power;
    logic watch_run;
    logic halted;
    logic fast_en_ff;
    logic watch_en_ff;
    logic sys_en_ff;
    logic sys_slow_ff;
    logic [1:0] fast_src_ff;
    logic [1:0] rc_freq_ff;
    logic [1:0] wdt_src_ff;
    logic [1:0] tb_src_ff;
    osc_pins_if pins_if ();

    // legal fast source decode; unknown codes fall back to the internal rc
    function automatic logic [1:0] legal_src(input logic [1:0] code);
        if (code == osc_sel_pkg::FAST_XTAL || code == osc_sel_pkg::FAST_EXT_RC)
        begin
            legal_src = code;
        end
        else
        begin
            legal_src = osc_sel_pkg::FAST_INT_RC;
        end
    endfunction

    // watch crystal availability per part type
    always_comb
    begin
        if (!CFG_WATCH_EN)
        begin
            watch_allowed = 1'b0;
        end
        else if (CFG_DEDICATED_PINS)
        begin
            watch_allowed = CFG_WATCH_PINS_OSC;
        end
        else
        begin
            watch_allowed = (legal_src(CFG_FAST_SRC) == osc_sel_pkg::FAST_INT_RC);
        end
    end

    // speed select only counts where a watch crystal exists
    assign speed_sel = system_control_reg_0_ff[osc_sel_pkg::SPEED_SEL_BIT] & watch_allowed;
    assign low_power = system_control_reg_0_ff[osc_sel_pkg::LOW_POWER_BIT];
    assign halted = (mode_ff == osc_sel_pkg::ST_IDLE) || (mode_ff == osc_sel_pkg::ST_SLEEP);

    // control register write
    always_ff @(posedge CLK)
    begin
        if (!RST_B)
        begin
            system_control_reg_0_ff <= osc_sel_pkg::SYSTEM_CONTROL_REG_0_RESET;
        end
        else if (WR && ADDR == osc_sel_pkg::ADDR_SYSTEM_CONTROL_REG_0)
        begin
            system_control_reg_0_ff <= WDATA & osc_sel_pkg::SYSTEM_CONTROL_REG_0_MASK;
        end
    end

    // operating mode transitions
    always_comb
    begin
        nxt_mode = mode_ff;
        case (mode_ff)
            osc_sel_pkg::ST_FAST:
            begin
                if (HALT)
                    nxt_mode = (watch_allowed && (!CFG_DEDICATED_PINS || WATCH_KEEP_IN_HALT))
                        ? osc_sel_pkg::ST_IDLE : osc_sel_pkg::ST_SLEEP;
                else if (speed_sel)
                    nxt_mode = osc_sel_pkg::ST_SLOW;
            end
            osc_sel_pkg::ST_SLOW:
            begin
                if (HALT)
                    nxt_mode = (!CFG_DEDICATED_PINS || WATCH_KEEP_IN_HALT)
                        ? osc_sel_pkg::ST_IDLE : osc_sel_pkg::ST_SLEEP;
                else if (!speed_sel)
                    nxt_mode = osc_sel_pkg::ST_FAST;
            end
            osc_sel_pkg::ST_IDLE, osc_sel_pkg::ST_SLEEP:
            begin
                if (WAKE)
                    nxt_mode = speed_sel ? osc_sel_pkg::ST_SLOW : osc_sel_pkg::ST_FAST;
            end
            default:
            begin
                nxt_mode = osc_sel_pkg::ST_FAST;
            end
        endcase
    end

    // mode register
    always_ff @(posedge CLK)
    begin
        if (!RST_B)
        begin
            mode_ff <= osc_sel_pkg::ST_FAST;
        end
        else
        begin
            mode_ff <= nxt_mode;
        end
    end

    // watch crystal runs where allowed unless sleeping; low-power bit never stops it
    assign watch_run = watch_allowed && (nxt_mode != osc_sel_pkg::ST_SLEEP);

    // oscillator enables and system clock gating
    always_ff @(posedge CLK)
    begin
        if (!RST_B)
        begin
            fast_en_ff <= 1'b1;
            watch_en_ff <= 1'b0;
            sys_en_ff <= 1'b1;
            sys_slow_ff <= 1'b0;
        end
        else
        begin
            fast_en_ff <= (nxt_mode == osc_sel_pkg::ST_FAST);
            watch_en_ff <= watch_run;
            sys_en_ff <= (nxt_mode == osc_sel_pkg::ST_FAST) || (nxt_mode == osc_sel_pkg::ST_SLOW);
            sys_slow_ff <= (nxt_mode == osc_sel_pkg::ST_SLOW);
        end
    end

    // fast source and internal rc frequency latched from options
    always_ff @(posedge CLK)
    begin
        if (!RST_B)
        begin
            fast_src_ff <= osc_sel_pkg::FAST_INT_RC;
            rc_freq_ff <= osc_sel_pkg::RC_4MHZ;
        end
        else
        begin
            fast_src_ff <= legal_src(CFG_FAST_SRC);
            rc_freq_ff <= (CFG_RC_FREQ == osc_sel_pkg::RC_12MHZ) ? osc_sel_pkg::RC_12MHZ
                : ((CFG_RC_FREQ == osc_sel_pkg::RC_8MHZ) ? osc_sel_pkg::RC_8MHZ : osc_sel_pkg::RC_4MHZ);
        end
    end

    // watchdog and time-base clock sources
    always_ff @(posedge CLK)
    begin
        if (!RST_B)
        begin
            wdt_src_ff <= osc_sel_pkg::SRC_SYS;
            tb_src_ff <= osc_sel_pkg::SRC_SYS;
        end
        else
        begin
            if (CFG_WDT_SRC_SYS || !CFG_SLOW_RC_EN)
                wdt_src_ff <= osc_sel_pkg::SRC_SYS;
            else
                wdt_src_ff <= osc_sel_pkg::SRC_SLOW_RC;
            tb_src_ff <= watch_run ? osc_sel_pkg::SRC_WATCH : osc_sel_pkg::SRC_SYS;
        end
    end

    // read data, valid the cycle after the strobe
    always_comb
    begin
        nxt_rdata = 8'h00;
        if (ADDR == osc_sel_pkg::ADDR_SYSTEM_CONTROL_REG_0)
        begin
            nxt_rdata = system_control_reg_0_ff;
        end
        else if (ADDR == osc_sel_pkg::ADDR_STATUS)
        begin
            nxt_rdata[osc_sel_pkg::ST_FAST_RUN_BIT] = fast_en_ff;
            nxt_rdata[osc_sel_pkg::ST_SLOW_RUN_BIT] = watch_en_ff;
            nxt_rdata[osc_sel_pkg::ST_SYS_GATE_BIT] = sys_en_ff;
            nxt_rdata[osc_sel_pkg::ST_SLOW_SYS_BIT] = sys_slow_ff;
            nxt_rdata[osc_sel_pkg::ST_LP_BIT] = low_power;
        end
    end

    always_ff @(posedge CLK)
    begin
        if (!RST_B)
        begin
            rdata_ff <= 8'h00;
        end
        else if (RD)
        begin
            rdata_ff <= nxt_rdata;
        end
        else
        begin
            rdata_ff <= 8'h00;
        end
    end

    // pin mapper connection
    assign pins_if.fast_src = fast_src_ff;
    assign pins_if.watch_on_main = watch_allowed && !CFG_DEDICATED_PINS;
    assign pins_if.watch_pins_osc = CFG_DEDICATED_PINS && CFG_WATCH_PINS_OSC;

    osc_pin_map u_pin_map (
        .CLK(CLK),
        .RST_B(RST_B),
        .pins(pins_if.map)
    );

    // outputs
    assign RDATA = rdata_ff;
    assign FAST_OSC_EN = fast_en_ff;
    assign FAST_OSC_SRC = fast_src_ff;
    assign RC_FREQ_SEL = rc_freq_ff;
    assign WATCH_OSC_EN = watch_en_ff;
    assign WATCH_LOW_POWER = low_power;
    assign SLOW_RC_EN = CFG_SLOW_RC_EN;
    assign SYS_CLK_EN = sys_en_ff;
    assign SYS_CLK_SLOW = sys_slow_ff;
    assign WDT_CLK_SRC = wdt_src_ff;
    assign TB_CLK_SRC = tb_src_ff;
    assign PA5_IS_IO = pins_if.pa5_io;
    assign PA6_IS_IO = pins_if.pa6_io;
    assign WATCH_PINS_IS_IO = pins_if.xt_io;
endmodule // osc_source_select

// ===== osc_sel_pkg.sv
// constants, types and rule summary for the oscillator source selector
//
// Behaviour
// - the slow-crystal low-power bit selects quick-start when 0 and low-power mode when 1.
// - power-on reset clears the slow-crystal low-power bit so the watch crystal starts in quick-start.
// - the watch crystal keeps running whatever the low-power bit holds; only start-up is longer.
// - the internal fast rc runs at 4, 8 or 12 MHz chosen by configuration option.
// - with the internal fast rc as system clock, port_a_bit5 and port_a_bit6 are free i/o; here both stay oscillator pins when the watch crystal sits on them.
// - with the external resistor oscillator, only osc_pin_a (port_a_bit6) is used and port_a_bit5 stays i/o.
// - on parts with dedicated watch pins an option chooses watch crystal or plain i/o for them.
// - on small parts the watch crystal is only available together with the internal fast rc.
// - on parts with dedicated watch pins the watch crystal may pair with any fast oscillator.
// - idle or sleep stops the system clock while the watch crystal may keep timers running.
// - the oscillators also supply clocks for the watchdog and the time base.
// - there are five oscillators: three fast, a 32768 Hz watch crystal and a 13 kHz internal rc.
// - the external crystal and resistor oscillators cover 400 kHz to 12 MHz.
// - the speed select bit picks the fast oscillator when 0, and the watch crystal with the fast one stopped when 1.
package osc_sel_pkg;
    // register map over the plain port
    localparam logic [7:0] ADDR_SYSTEM_CONTROL_REG_0 = 8'h00;
    localparam logic [7:0] ADDR_STATUS = 8'h01;
    // control register fields and reset values
    localparam int SPEED_SEL_BIT = 0;
    localparam int LOW_POWER_BIT = 1;
    localparam logic [7:0] SYSTEM_CONTROL_REG_0_RESET = 8'h00;
    localparam logic [7:0] SYSTEM_CONTROL_REG_0_MASK = 8'h03;
    // status register fields
    localparam int ST_FAST_RUN_BIT = 0;
    localparam int ST_SLOW_RUN_BIT = 1;
    localparam int ST_SYS_GATE_BIT = 2;
    localparam int ST_SLOW_SYS_BIT = 3;
    localparam int ST_LP_BIT = 4;
    // fast oscillator choices (configuration option)
    typedef enum logic [1:0] {
        FAST_XTAL = 2'h0,
        FAST_EXT_RC = 2'h1,
        FAST_INT_RC = 2'h2
    } fast_src_t;
    // internal fast rc frequency choices
    typedef enum logic [1:0] {
        RC_4MHZ = 2'h0,
        RC_8MHZ = 2'h1,
        RC_12MHZ = 2'h2
    } rc_freq_t;
    localparam int RC_4MHZ_KHZ = 4000;
    localparam int RC_8MHZ_KHZ = 8000;
    localparam int RC_12MHZ_KHZ = 12000;
    localparam int EXT_MIN_KHZ = 400;
    localparam int EXT_MAX_KHZ = 12000;
    localparam int WATCH_XTAL_HZ = 32768;
    localparam int SLOW_RC_HZ = 13000;
    // clock-source codes for watchdog and time base
    localparam logic [1:0] SRC_SYS = 2'h0;
    localparam logic [1:0] SRC_WATCH = 2'h1;
    localparam logic [1:0] SRC_SLOW_RC = 2'h2;
    // system clock mode state (one-hot)
    typedef enum logic [3:0] {
        ST_FAST = 4'h1,
        ST_SLOW = 4'h2,
        ST_IDLE = 4'h4,
        ST_SLEEP = 4'h8
    } mode_t;
endpackage

// ===== osc_pins_if.sv
// pin-release information passed from the selector to the pin mapper
`timescale 1ns/1ps
interface osc_pins_if;
    logic [1:0] fast_src;
    logic watch_on_main;
    logic watch_pins_osc;
    logic pa5_io;
    logic pa6_io;
    logic xt_io;
    modport ctrl (output fast_src, output watch_on_main, output watch_pins_osc, input pa5_io, input pa6_io,
        input xt_io);
    modport map (input fast_src, input watch_on_main, input watch_pins_osc, output pa5_io, output pa6_io,
        output xt_io);
endinterface

// ===== osc_pin_map.sv
// decides which oscillator pins revert to general i/o
`timescale 1ns/1ps
module osc_pin_map (
    input wire logic CLK,
    input wire logic RST_B,
    osc_pins_if.map pins
);
    logic nxt_pa5;
    logic nxt_pa6;
    logic pa5_ff;
    logic pa6_ff;
    logic xt_ff;

    // pin release decode
    always_comb
    begin
        nxt_pa5 = 1'b0;
        nxt_pa6 = 1'b0;
        if (pins.watch_on_main)
        begin
            nxt_pa5 = 1'b0;
            nxt_pa6 = 1'b0;
        end
        else if (pins.fast_src == osc_sel_pkg::FAST_INT_RC)
        begin
            nxt_pa5 = 1'b1;
            nxt_pa6 = 1'b1;
        end
        else if (pins.fast_src == osc_sel_pkg::FAST_EXT_RC)
        begin
            nxt_pa5 = 1'b1;
            nxt_pa6 = 1'b0;
        end
    end

    // registered pin functions, all i/o held as oscillator at reset
    always_ff @(posedge CLK)
    begin
        if (!RST_B)
        begin
            pa5_ff <= 1'b0;
            pa6_ff <= 1'b0;
            xt_ff <= 1'b0;
        end
        else
        begin
            pa5_ff <= nxt_pa5;
            pa6_ff <= nxt_pa6;
            xt_ff <= ~pins.watch_pins_osc;
        end
    end

    assign pins.pa5_io = pa5_ff;
    assign pins.pa6_io = pa6_ff;
    assign pins.xt_io = xt_ff;
endmodule // osc_pin_map

// ===== osc_source_select_sva.sv
// port assertions for the oscillator source selector
`timescale 1ns/1ps
module osc_source_select_chk (
    input wire logic CLK,
    input wire logic RST_B,
    input wire logic [1:0] CFG_FAST_SRC,
    input wire logic CFG_WATCH_EN,
    input wire logic CFG_SLOW_RC_EN,
    input wire logic CFG_WDT_SRC_SYS,
    input wire logic HALT,
    input wire logic WAKE,
    input wire logic [7:0] ADDR,
    input wire logic [7:0] WDATA,
    input wire logic WR,
    input wire logic RD,
    input wire logic [7:0] RDATA,
    input wire logic FAST_OSC_EN,
    input wire logic WATCH_LOW_POWER,
    input wire logic SLOW_RC_EN,
    input wire logic SYS_CLK_EN,
    input wire logic SYS_CLK_SLOW,
    input wire logic [1:0] WDT_CLK_SRC,
    input wire logic PA5_IS_IO,
    input wire logic PA6_IS_IO
);
    default clocking cb @(posedge CLK); endclocking
    default disable iff (!RST_B);
    // read data only in the cycle after a read
    rdata_idle_a: assert property ($past(RD) == 1'b0 |-> RDATA == 8'h00) else $error("read data not idle");
    lp_follow_a: assert property (WR && ADDR == osc_sel_pkg::ADDR_SYSTEM_CONTROL_REG_0
        |=> WATCH_LOW_POWER == $past(WDATA[osc_sel_pkg::LOW_POWER_BIT])) else $error("low power bit wrong");
    halt_gate_a: assert property (HALT && SYS_CLK_EN |=> !SYS_CLK_EN [*2]) else $error("clock not gated");
    wake_run_a: assert property (WAKE && !SYS_CLK_EN |=> SYS_CLK_EN) else $error("clock not restored");
    halt_fast_a: assert property (!SYS_CLK_EN |-> !FAST_OSC_EN) else $error("fast osc runs in halt");
    slow_excl_a: assert property (SYS_CLK_SLOW |-> !FAST_OSC_EN && SYS_CLK_EN) else $error("fast osc in slow");
    rc_pins_a: assert property ($past(RST_B) && $past(RST_B, 2) && $past(CFG_FAST_SRC[1] && !CFG_WATCH_EN)
        && $past(CFG_FAST_SRC[1] && !CFG_WATCH_EN, 2)
        && CFG_FAST_SRC[1] && !CFG_WATCH_EN |-> PA5_IS_IO && PA6_IS_IO) else $error("rc pins not free");
    erc_pins_a: assert property ($past(RST_B) && $past(RST_B, 2) && $past(CFG_FAST_SRC) == 2'h1
        && $past(CFG_FAST_SRC, 2) == 2'h1
        && CFG_FAST_SRC == 2'h1 |-> PA5_IS_IO && !PA6_IS_IO) else $error("resistor osc pins wrong");
    wdt_sys_a: assert property ($past(RST_B) && $past(CFG_WDT_SRC_SYS) && CFG_WDT_SRC_SYS
        |-> WDT_CLK_SRC == osc_sel_pkg::SRC_SYS) else $error("watchdog source wrong");
    slow_rc_a: assert property (SLOW_RC_EN == CFG_SLOW_RC_EN) else $error("slow rc enable wrong");
    // main scenarios reached
    halt_c: cover property (HALT && SYS_CLK_EN);
    slow_c: cover property (SYS_CLK_SLOW);
    read_c: cover property (RD ##1 RDATA != 8'h00);
endmodule // osc_source_select_chk

bind osc_source_select osc_source_select_chk osc_source_select_chk_i (.CLK(CLK), .RST_B(RST_B),
    .CFG_FAST_SRC(CFG_FAST_SRC), .CFG_WATCH_EN(CFG_WATCH_EN), .CFG_SLOW_RC_EN(CFG_SLOW_RC_EN),
    .CFG_WDT_SRC_SYS(CFG_WDT_SRC_SYS), .HALT(HALT), .WAKE(WAKE), .ADDR(ADDR), .WDATA(WDATA), .WR(WR),
    .RD(RD), .RDATA(RDATA), .FAST_OSC_EN(FAST_OSC_EN), .WATCH_LOW_POWER(WATCH_LOW_POWER),
    .SLOW_RC_EN(SLOW_RC_EN), .SYS_CLK_EN(SYS_CLK_EN), .SYS_CLK_SLOW(SYS_CLK_SLOW),
    .WDT_CLK_SRC(WDT_CLK_SRC), .PA5_IS_IO(PA5_IS_IO), .PA6_IS_IO(PA6_IS_IO));

// ===== osc_parts_model.sv
// behavioural model of the crystals and rc parts on the oscillator pins
`timescale 1ns/1ps
module osc_parts_model (
    input wire logic fast_en,
    input wire logic watch_en,
    input wire logic low_power,
    output logic fast_running,
    output logic watch_running
);
    // crystal swings whenever enabled; low power only stretches start-up
    assign watch_running = watch_en && (low_power || !low_power);
    assign fast_running = fast_en;
endmodule // osc_parts_model

// ===== osc_source_select_tb.sv
// self-checking testbench for the oscillator source selector
`timescale 1ns/1ps
module osc_source_select_tb;
    logic CLK, RST_B, CFG_WATCH_EN, CFG_DEDICATED_PINS, CFG_WATCH_PINS_OSC, CFG_SLOW_RC_EN, CFG_WDT_SRC_SYS;
    logic HALT, WAKE, WATCH_KEEP_IN_HALT, WR, RD, FAST_OSC_EN, WATCH_OSC_EN, WATCH_LOW_POWER, SLOW_RC_EN;
    logic SYS_CLK_EN, SYS_CLK_SLOW, PA5_IS_IO, PA6_IS_IO, WATCH_PINS_IS_IO, fast_running, watch_running;
    logic [1:0] CFG_FAST_SRC, CFG_RC_FREQ, FAST_OSC_SRC, RC_FREQ_SEL, WDT_CLK_SRC, TB_CLK_SRC, s, f;
    logic [7:0] ADDR, WDATA, RDATA, v;
    logic w, d, k, ok;
    int mismatches, compares;

    osc_source_select osc_source_select_i (.*);
    osc_parts_model osc_parts_model_i (.fast_en(FAST_OSC_EN), .watch_en(WATCH_OSC_EN),
        .low_power(WATCH_LOW_POWER), .fast_running(fast_running), .watch_running(watch_running));

    // 50 MHz clock
    initial CLK = 1'b0;
    always #10 CLK = ~CLK;

    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        compares++;
        if (got !== exp)
        begin
            mismatches++;
            $display("BAD %0t got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic wr(input logic [7:0] a, input logic [7:0] dt);
        @(posedge CLK);
        WR <= 1'b1;
        ADDR <= a;
        WDATA <= dt;
        @(posedge CLK);
        WR <= 1'b0;
    endtask

    task automatic rd(input logic [7:0] a, output logic [7:0] dt);
        @(posedge CLK);
        RD <= 1'b1;
        ADDR <= a;
        @(posedge CLK);
        RD <= 1'b0;
        #1;
        dt = RDATA;
    endtask

    task automatic pulse(input logic h);
        @(posedge CLK);
        HALT <= h;
        WAKE <= !h;
        @(posedge CLK);
        HALT <= 1'b0;
        WAKE <= 1'b0;
        @(posedge CLK);
        #1;
    endtask

    // pin roles expected: {watch pins, pa6, pa5} high when i/o
    function automatic logic [2:0] exp_pins(input logic [1:0] src, input logic we, input logic ded);
        logic wom;
        wom = we && !ded && src[1];
        return {!ded || !we, src[1] && !wom, (src[1] && !wom) || (src == 2'h1)};
    endfunction

    task automatic stop_test();
        if (mismatches == 0 && compares > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask

    // watchdog against a hang
    initial
    begin
        repeat (20000) @(posedge CLK);
        mismatches++;
        stop_test();
    end

    initial
    begin
        mismatches = 0;
        compares = 0;
        {HALT, WAKE, WR, RD, ADDR, WDATA} = '0;
        {CFG_FAST_SRC, CFG_RC_FREQ, CFG_WATCH_EN, CFG_DEDICATED_PINS, CFG_WATCH_PINS_OSC} = '0;
        {CFG_SLOW_RC_EN, CFG_WDT_SRC_SYS, WATCH_KEEP_IN_HALT} = 3'h7;
        RST_B = 1'b0;
        repeat (6) @(posedge CLK);
        RST_B <= 1'b1;
        void'($urandom(71));
        // reset state and unmapped read
        chk(WATCH_LOW_POWER, 1'b0);
        rd(8'h00, v);
        chk(v, 8'h00);
        rd(8'h01, v);
        chk(v, 8'h05);
        rd(8'h07, v);
        chk(v, 8'h00);
        for (int i = 0; i < 24; i++)
        begin
            {s, f, w, d, k} = 7'($urandom());
            if (i == 0)
                {s, w, d} = 4'hA;
            if (i == 1)
                {s, w, d} = 4'h4;
            ok = w && (d || s[1]);
            @(posedge CLK);
            CFG_FAST_SRC <= s;
            CFG_RC_FREQ <= f;
            CFG_WATCH_EN <= w;
            CFG_DEDICATED_PINS <= d;
            CFG_WATCH_PINS_OSC <= w;
            CFG_SLOW_RC_EN <= k;
            CFG_WDT_SRC_SYS <= f[0] || !k;
            WATCH_KEEP_IN_HALT <= k;
            repeat (3) @(posedge CLK);
            #1;
            chk(FAST_OSC_SRC, (s == 2'h3) ? 2'h2 : s);
            chk(RC_FREQ_SEL, (f == 2'h3) ? 2'h0 : f);
            chk({WATCH_PINS_IS_IO, PA6_IS_IO, PA5_IS_IO}, exp_pins(s, w, d));
            chk(SLOW_RC_EN, k);
            chk(WDT_CLK_SRC, (f[0] || !k) ? 2'h0 : 2'h2);
            chk(TB_CLK_SRC, {1'b0, ok});
            chk(WATCH_OSC_EN, ok);
            // slow mode with low power, then halt and wake
            wr(8'h00, 8'h03);
            repeat (3) @(posedge CLK);
            #1;
            chk({FAST_OSC_EN, SYS_CLK_SLOW, WATCH_LOW_POWER}, {!ok, ok, 1'b1});
            chk(watch_running, ok);
            rd(8'h00, v);
            chk(v, 8'h03);
            pulse(1'b1);
            chk({SYS_CLK_EN, fast_running, watch_running}, {2'b00, ok && (!d || k)});
            pulse(1'b0);
            chk({SYS_CLK_EN, SYS_CLK_SLOW}, {1'b1, ok});
            wr(8'h00, 8'hFC);
            rd(8'h00, v);
            chk(v, 8'h00);
        end
        stop_test();
    end
endmodule // osc_source_select_tb
